// file: hw/stmd_host.sv
`default_nettype none
module stmd_host
	import stmd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	// processor side
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic cpu_nibble_mode,
	output logic [7:0] cpu_rdata,
	output logic cpu_rdata_oe,
	output logic cpu_code_error,
	// transceiver side
	output logic [3:0] driver_mode_code,
	output logic [3:0] receiver_mode_code,
	output logic timing_driver_select,
	output logic remote_loop_out,
	output logic local_loop_out,
	input wire logic ring_indicator_in,
	input wire logic timing_receiver_out,
	input wire logic receive_clock_out,
	// serial controller side
	output logic scc_wr_sel,
	output logic scc_rd_sel,
	output logic scc_tx_clock_edge,
	output logic scc_rx_clock_edge
);
	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic stmd_sel_t decode(input logic [7:0] a, input logic is_rd);
		if ((a & STMD_ADDR_SCC_MASK) == STMD_ADDR_SCC_BASE)
			return STMD_SEL_SCC;
		else if (!is_rd && a == STMD_ADDR_MODE)
			return STMD_SEL_MODE;
		else if (!is_rd && a == STMD_ADDR_LOOP)
			return STMD_SEL_LOOP;
		else if (is_rd && a == STMD_ADDR_RING)
			return STMD_SEL_RING;
		else
			return STMD_SEL_NONE;
	endfunction

	stmd_req_t req;
	stmd_sel_t wsel;
	stmd_sel_t rsel;
	stmd_mode_t mode_q;
	stmd_loop_t loop_q;
	logic [2:0] sync_level;
	logic [2:0] sync_rise;
	logic [3:0] wr_drv;
	logic [3:0] wr_rcv;

	assign req = '{addr: cpu_addr, wdata: cpu_wdata, wr: cpu_wr, rd: cpu_rd};
	assign wsel = req.wr ? decode(req.addr, 1'b0) : STMD_SEL_NONE; // RULE_11
	assign rsel = (req.rd && !req.wr) ? decode(req.addr, 1'b1) : STMD_SEL_NONE; // RULE_11

	// ------------------------------------------------------------
	// pin input synchronisers
	// ------------------------------------------------------------
	stmd_sync #(.WIDTH(3)) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in({receive_clock_out, timing_receiver_out, ring_indicator_in}),
		.level_q(sync_level),
		.rise_q(sync_rise)
	);

	// ------------------------------------------------------------
	// mode select latch
	// ------------------------------------------------------------
	// nibble mode: one 4-bit value feeds both codes bit for bit
	assign wr_drv = cpu_nibble_mode ? req.wdata[3:0] : // RULE_08
		req.wdata[STMD_MODE_DRV_LSB +: 4];
	assign wr_rcv = cpu_nibble_mode ? req.wdata[3:0] : // RULE_08
		req.wdata[STMD_MODE_RCV_LSB +: 4];

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= stmd_mode_t'(STMD_MODE_RST); // RULE_21
			cpu_code_error <= 1'b0;
		end else if (wsel == STMD_SEL_MODE) begin
			// undefined codes refused, latch keeps old value
			if (stmd_code_defined(wr_drv) && stmd_code_defined(wr_rcv)) begin // RULE_05
				mode_q.driver_mode_code <= wr_drv; // RULE_07
				mode_q.receiver_mode_code <= wr_rcv; // RULE_07
				cpu_code_error <= 1'b0;
			end else begin
				cpu_code_error <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			driver_mode_code <= STMD_CODE_OFF;
			receiver_mode_code <= STMD_CODE_OFF;
		end else begin
			driver_mode_code <= mode_q.driver_mode_code; // RULE_06
			receiver_mode_code <= mode_q.receiver_mode_code; // RULE_06
		end
	end

	// ------------------------------------------------------------
	// loopback latch
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			loop_q <= stmd_loop_t'(STMD_LOOP_RST);
		end else if (wsel == STMD_SEL_LOOP) begin
			loop_q.remote_loop <= req.wdata[STMD_LOOP_REMOTE_BIT]; // RULE_09
			loop_q.local_loop <= req.wdata[STMD_LOOP_LOCAL_BIT]; // RULE_09
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			remote_loop_out <= 1'b0;
			local_loop_out <= 1'b0;
		end else begin
			remote_loop_out <= loop_q.remote_loop;
			local_loop_out <= loop_q.local_loop;
		end
	end

	// ------------------------------------------------------------
	// ring indicator read port and controller selects
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			cpu_rdata <= 8'h00;
			cpu_rdata_oe <= 1'b0;
		end else begin
			cpu_rdata <= 8'h00;
			cpu_rdata_oe <= 1'b0;
			if (rsel == STMD_SEL_RING) begin
				cpu_rdata[STMD_RING_BIT] <= sync_level[0]; // RULE_10
				cpu_rdata_oe <= 1'b1; // RULE_10
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			scc_wr_sel <= 1'b0;
			scc_rd_sel <= 1'b0;
		end else begin
			scc_wr_sel <= (wsel == STMD_SEL_SCC); // RULE_11
			scc_rd_sel <= (rsel == STMD_SEL_SCC); // RULE_11
		end
	end

	// ------------------------------------------------------------
	// timing clocks: dte takes both clocks from the far end
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			timing_driver_select <= 1'b0;
			scc_tx_clock_edge <= 1'b0;
			scc_rx_clock_edge <= 1'b0;
		end else begin
			timing_driver_select <= 1'b1; // RULE_12
			scc_tx_clock_edge <= sync_rise[1]; // RULE_12
			scc_rx_clock_edge <= sync_rise[2]; // RULE_12
		end
	end
endmodule
`default_nettype wire

// file: hw/stmd_pkg.sv
// Contract
// (RULE_01) transceiver decodes mode codes combinationally; outputs follow code inputs continuously
// (RULE_02) driver code 0000 puts every line driver in high impedance
// (RULE_03) receiver code 0000 leaves receiver logic outputs undetermined
// (RULE_04) receiver outputs never float; they follow their line inputs
// (RULE_05) host programs only defined driver and receiver mode codes
// (RULE_06) separate 4-bit driver and receiver codes, eight control bits total
// (RULE_07) host mode latch is 8 bits from data bus, both nibbles in one write
// (RULE_08) alternative: one 4-bit latch driving driver and receiver bits together
// (RULE_09) host keeps 2-bit latch for remote and local loopback signals
// (RULE_10) host 1-bit tri-state read port returns ring indicator level
// (RULE_11) host address decode gives distinct selects for controller, latches, ring port
// (RULE_12) timing select high: transmit clock from terminal timing, receive clock separate
// (RULE_13) open single-ended receiver input yields logic high output
// (RULE_14) low-speed single-ended receivers: all signals RS232, control lines V.35
// (RULE_15) RS449 and EIA530 use RS423-type receiver only for incoming call
// (RULE_16) differential receivers for clock, data, some control; V.35 clock and data
// (RULE_17) codes: RS232 0010, V.35 1110, RS422 0100, RS485 0101, RS449 1100, EIA530 1101
// (RULE_18) timing select high enables send-timing drivers, disables terminal-timing drivers
// (RULE_19) timing receiver stays connected to terminal-timing pins regardless of select
// (RULE_20) send-timing and terminal-timing drivers never enabled together
// (RULE_21) host mode latch resets to driver code 0000
`default_nettype none
package stmd_pkg;
	localparam logic [3:0] STMD_CODE_OFF = 4'h0;
	localparam logic [3:0] STMD_CODE_RS232 = 4'h2;
	localparam logic [3:0] STMD_CODE_V35 = 4'he;
	localparam logic [3:0] STMD_CODE_RS422 = 4'h4;
	localparam logic [3:0] STMD_CODE_RS485 = 4'h5;
	localparam logic [3:0] STMD_CODE_RS449 = 4'hc;
	localparam logic [3:0] STMD_CODE_EIA530 = 4'hd;
	// host i/o address map
	localparam logic [7:0] STMD_ADDR_SCC_BASE = 8'h00;
	localparam logic [7:0] STMD_ADDR_SCC_MASK = 8'hf0;
	localparam logic [7:0] STMD_ADDR_MODE = 8'h10;
	localparam logic [7:0] STMD_ADDR_LOOP = 8'h11;
	localparam logic [7:0] STMD_ADDR_RING = 8'h11;
	// field layout
	localparam int STMD_MODE_DRV_LSB = 0;
	localparam int STMD_MODE_RCV_LSB = 4;
	localparam int STMD_LOOP_REMOTE_BIT = 0;
	localparam int STMD_LOOP_LOCAL_BIT = 1;
	localparam int STMD_RING_BIT = 0;
	// reset values
	localparam logic [7:0] STMD_MODE_RST = 8'h00;
	localparam logic [1:0] STMD_LOOP_RST = 2'h0;
	typedef enum logic [2:0] {
		STMD_SEL_NONE = 3'b000,
		STMD_SEL_SCC = 3'b001,
		STMD_SEL_MODE = 3'b010,
		STMD_SEL_LOOP = 3'b011,
		STMD_SEL_RING = 3'b100
	} stmd_sel_t;
	typedef struct packed {
		logic [3:0] receiver_mode_code;
		logic [3:0] driver_mode_code;
	} stmd_mode_t;
	typedef struct packed {
		logic local_loop;
		logic remote_loop;
	} stmd_loop_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} stmd_req_t;
	function automatic logic stmd_code_defined(input logic [3:0] c);
		return c == STMD_CODE_OFF || c == STMD_CODE_RS232 || c == STMD_CODE_V35 ||
			c == STMD_CODE_RS422 || c == STMD_CODE_RS485 || c == STMD_CODE_RS449 ||
			c == STMD_CODE_EIA530;
	endfunction
endpackage
`default_nettype wire

// file: hw/stmd_sync.sv
`default_nettype none
module stmd_sync
	import stmd_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_q,
	output logic [WIDTH-1:0] rise_q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	// change counts once second and third stage agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock) begin
				if (rst) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					level_q[i] <= 1'b0;
					rise_q[i] <= 1'b0;
				end else begin
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					rise_q[i] <= 1'b0;
					if (s2_q[i] == s3_q[i]) begin
						level_q[i] <= s3_q[i];
						rise_q[i] <= s3_q[i] & ~level_q[i];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: bench/stmd_host_assertions.sv
`default_nettype none
module stmd_host_assertions import stmd_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic cpu_nibble_mode,
	input wire logic cpu_rdata_oe,
	input wire logic cpu_code_error,
	input wire logic [3:0] driver_mode_code,
	input wire logic [3:0] receiver_mode_code,
	input wire logic timing_driver_select,
	input wire logic local_loop_out,
	input wire logic remote_loop_out,
	input wire logic timing_receiver_out,
	input wire logic receive_clock_out,
	input wire logic scc_wr_sel,
	input wire logic scc_rd_sel,
	input wire logic scc_tx_clock_edge,
	input wire logic scc_rx_clock_edge
);
	// ----
	// host side checks
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic mw, ok, sa;
	assign mw = cpu_wr && cpu_addr == STMD_ADDR_MODE;
	// nibble mode feeds both codes from the low nibble only
	assign ok = stmd_code_defined(cpu_wdata[3:0]) &&
		(cpu_nibble_mode || stmd_code_defined(cpu_wdata[7:4]));
	assign sa = (cpu_addr & STMD_ADDR_SCC_MASK) == STMD_ADDR_SCC_BASE;
	property p_mode; mw && ok && !cpu_nibble_mode ##1 !cpu_wr |=>
		{receiver_mode_code, driver_mode_code} == $past(cpu_wdata, 2); endproperty
	a_mode: assert property (p_mode) else $error("mode byte not applied");
	property p_nib; mw && ok && cpu_nibble_mode ##1 !cpu_wr |=> receiver_mode_code ==
		$past(cpu_wdata[3:0], 2) && driver_mode_code == receiver_mode_code; endproperty
	a_nib: assert property (p_nib) else $error("nibble write wrong");
	property p_refuse; mw && !ok ##1 !cpu_wr |=>
		$stable({receiver_mode_code, driver_mode_code}) && cpu_code_error; endproperty
	a_refuse: assert property (p_refuse) else $error("bad code not refused");
	property p_reset; $past(rst) |->
		driver_mode_code == STMD_CODE_OFF ##1 timing_driver_select [*3]; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_loop; cpu_wr && cpu_addr == STMD_ADDR_LOOP ##1 !cpu_wr |=>
		{local_loop_out, remote_loop_out} == $past(cpu_wdata[1:0], 2); endproperty
	a_loop: assert property (p_loop) else $error("loop latch wrong");
	property p_ring; cpu_rdata_oe == $past(cpu_rd && !cpu_wr && cpu_addr == STMD_ADDR_RING);
	endproperty
	a_ring: assert property (p_ring) else $error("ring buffer enable wrong");
	property p_scc; scc_wr_sel == $past(cpu_wr && sa) &&
		scc_rd_sel == $past(cpu_rd && !cpu_wr && sa); endproperty
	a_scc: assert property (p_scc) else $error("controller select wrong");
	property p_edge; $rose(timing_receiver_out) |-> ##[1:6] scc_tx_clock_edge; endproperty
	a_edge: assert property (p_edge) else $error("transmit clock edge lost");
	// two low and two high samples, so the synchroniser settles on both levels
	property p_rxedge; !receive_clock_out ##1 !receive_clock_out ##1 receive_clock_out [*2] |->
		##[1:6] scc_rx_clock_edge; endproperty
	a_rxedge: assert property (p_rxedge) else $error("receive clock edge lost");
endmodule
bind stmd_host stmd_host_assertions u_chk(.*);
`default_nettype wire

// file: bench/stmd_xcvr_model.sv
`default_nettype none
module stmd_xcvr_model (
	input wire logic [3:0] driver_mode_code,
	input wire logic [3:0] receiver_mode_code,
	input wire logic timing_driver_select,
	input wire logic line_clock,
	input wire logic ring_line,
	output logic timing_receiver_out,
	output logic receive_clock_out,
	output logic ring_indicator_in,
	output logic send_timing_on,
	output logic term_timing_on
);
	// ----
	// transceiver decode
	// ----
	logic drv_on, rcv_on;
	assign drv_on = driver_mode_code != 4'h0;
	assign rcv_on = receiver_mode_code != 4'h0;
	assign send_timing_on = drv_on && timing_driver_select;
	assign term_timing_on = drv_on && !timing_driver_select;
	assign timing_receiver_out = line_clock;
	// off code: inverted clock stands in for undetermined
	assign receive_clock_out = rcv_on ? line_clock : ~line_clock;
	// open single-ended input reads high
	assign ring_indicator_in = rcv_on ? ring_line : 1'b1;
endmodule
`default_nettype wire

// file: bench/stmd_host_test.sv
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module stmd_host_test import stmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, cpu_nibble_mode = 0, line_clock = 0;
	logic ring_line = 0, cpu_rdata_oe, cpu_code_error, timing_driver_select, remote_loop_out;
	logic local_loop_out, ring_indicator_in, timing_receiver_out, receive_clock_out, scc_wr_sel;
	logic scc_rd_sel, scc_tx_clock_edge, scc_rx_clock_edge, send_timing_on, term_timing_on, nib;
	logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, d, lp, em = 8'h00;
	logic [3:0] driver_mode_code, receiver_mode_code;
	logic [3:0] codes [7] = '{4'h0, 4'h2, 4'he, 4'h4, 4'h5, 4'hc, 4'hd};
	int failures = 0, comparisons = 0, cycles = 0;
	stmd_host u_dut(.*);
	stmd_xcvr_model u_xcvr(.*);
	// ----
	// expectations and bus cycles
	// ----
	function automatic logic ok4(logic [3:0] c);
		return c inside {codes};
	endfunction
	function automatic logic [7:0] next_mode(logic [7:0] old, logic [7:0] w, logic n);
		if (!ok4(w[3:0]) || !ok4(w[7:4]))
			return old;
		return n ? {2{w[3:0]}} : w;
	endfunction
	task automatic req(input logic w, r, n, input logic [7:0] a, v);
		@(posedge clock);
		cpu_wr <= w;
		cpu_rd <= r;
		cpu_nibble_mode <= n;
		cpu_addr <= a;
		cpu_wdata <= v;
		@(posedge clock);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		@(negedge clock);
	endtask
	task automatic report_and_stop;
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial forever #10 clock = ~clock;
	initial begin
		#7;
		forever #80 line_clock = ~line_clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h4ec1));
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK(driver_mode_code, 4'h0)
		for (int i = 0; i < 40; i++) begin
			nib = i > 6 && $urandom % 2;
			d = i < 7 ? {codes[6 - i], codes[i]} : 8'($urandom);
			if (nib)
				d[7:4] = codes[$urandom % 7];
			req(1'b1, 1'b0, nib, STMD_ADDR_MODE, d);
			@(negedge clock);
			em = next_mode(em, d, nib);
			`CHK({receiver_mode_code, driver_mode_code}, em)
			`CHK(cpu_code_error, !(ok4(d[3:0]) && ok4(d[7:4])))
			`CHK({send_timing_on, term_timing_on}, {em[3:0] != 4'h0, 1'b0})
			lp = 8'($urandom);
			req(1'b1, 1'b0, nib, STMD_ADDR_LOOP, lp);
			@(negedge clock);
			`CHK({local_loop_out, remote_loop_out}, lp[1:0])
			ring_line <= 1'($urandom);
			repeat (5) @(posedge clock);
			req(1'b0, 1'b1, nib, STMD_ADDR_RING, 8'h00);
			`CHK({cpu_rdata_oe, cpu_rdata}, {8'h80, ring_line | ~|em[7:4]})
			req(1'b1, 1'b1, nib, 8'($urandom % 16), d);
			`CHK({scc_wr_sel, scc_rd_sel, cpu_rdata_oe}, 3'b100)
			req(1'b0, 1'b1, nib, 8'h20 + 8'($urandom % 8), 8'h00);
			`CHK({scc_rd_sel, cpu_rdata_oe, cpu_rdata}, 10'h000)
			req(1'b0, 1'b1, nib, 8'($urandom % 16), 8'h00);
			`CHK({scc_wr_sel, scc_rd_sel, cpu_rdata_oe}, 3'b010)
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
